// >>> src/fmsi_consts.svh
// Purpose: Constants of the fan motor speed input and start-up block.
// Assumes: 125 MHz pclk, speed command sampled at 25 MHz.
// Notes:   Offsets are APB byte addresses, one 32-bit word each.
`ifndef FMSI_CONSTS_SVH
`define FMSI_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define FMSI_CLK_MHZ 125
`define FMSI_CLK_NS 8
`define FMSI_SAMPLE_NS 40
`define FMSI_SAMPLE_MHZ 25
`define FMSI_SAMPLE_CYC (`FMSI_SAMPLE_NS / `FMSI_CLK_NS)
`define FMSI_INIT_US 2000
`define FMSI_INIT_CYC (`FMSI_INIT_US * `FMSI_CLK_MHZ)
`define FMSI_DEF_PWM_KHZ 58
`define FMSI_DEF_PERIOD (`FMSI_SAMPLE_MHZ * 1000 / `FMSI_DEF_PWM_KHZ)
`define FMSI_FULL_MULT 7
`define FMSI_STARTUP_HALLS 4
`define FMSI_MIN_LOW_NS 500

// ****************************************************************
// Register map
// ****************************************************************
`define FMSI_REG_CTRL 12'h000
`define FMSI_REG_LEVEL 12'h004
`define FMSI_REG_FLOOR 12'h008
`define FMSI_REG_STATUS 12'h00c
`define FMSI_REG_PERIOD 12'h010
`define FMSI_REG_HIGH 12'h014
`define FMSI_REG_SHIFT 12'h018
`define FMSI_IX_CTRL 3'h0
`define FMSI_IX_LEVEL 3'h1
`define FMSI_IX_FLOOR 3'h2
`define FMSI_IX_STATUS 3'h3
`define FMSI_IX_PERIOD 3'h4
`define FMSI_IX_HIGH 3'h5
`define FMSI_IX_SHIFT 3'h6
`define FMSI_IX_NONE 3'h7

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define FMSI_CTRL_DC_BIT 0
`define FMSI_CTRL_PS_BIT 1
`define FMSI_CTRL_FGS_LSB 2
`define FMSI_ST_FULL_BIT 0
`define FMSI_ST_VALID_BIT 1
`define FMSI_ST_STATE_LSB 2
`define FMSI_ST_HALL_BIT 5
`define FMSI_CTRL_RST 4'h0
`define FMSI_LEVEL_RST 32'h0
`define FMSI_FLOOR_RST 32'h0

`endif

// >>> src/fmsi_pkg.sv
// Purpose: Shared types of the fan motor speed input block.
// Assumes: Nothing beyond the constants header.
// Notes:   Start-up states are one-hot.
package fmsi_pkg;
    typedef enum logic [2:0] {
        FMSI_ST_INIT = 3'b001,
        FMSI_ST_START = 3'b010,
        FMSI_ST_RUN = 3'b100
    } fmsi_state_t;
endpackage

// >>> src/fmsi_cmd_meter.sv
// Purpose: Measures period and high time of the speed command.
// Assumes: tick is a one-cycle strobe at the sampling rate.
// Notes:   Counters saturate at all ones.
`include "fmsi_consts.svh"
module fmsi_cmd_meter #(
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic clear,
    input wire logic hold,
    input wire logic cmd,
    output logic cmd_lvl,
    output logic [CW-1:0] high_run,
    output logic [CW-1:0] period,
    output logic [CW-1:0] high,
    output logic valid
);
    import fmsi_pkg::*;
    typedef struct packed {
        logic lvl;
        logic seen;
        logic skip;
        logic [CW-1:0] tot;
        logic [CW-1:0] hi;
        logic [CW-1:0] period;
        logic [CW-1:0] high;
        logic valid;
    } fmsi_meter_t;
    fmsi_meter_t s, nxt;

    always_comb begin
        nxt = s;
        nxt.skip = s.skip | hold;
        if (clear) begin
            nxt = '0;
        end else if (tick) begin
            nxt.lvl = cmd;
            if (cmd && !s.lvl) begin
                // A period spanning a full-duty stretch is meaningless
                if (s.seen && !s.skip && !hold) begin
                    nxt.period = s.tot;
                    nxt.high = s.hi;
                    nxt.valid = 1'b1;
                end
                nxt.seen = 1'b1;
                nxt.skip = 1'b0;
                nxt.tot = CW'(1);
                nxt.hi = CW'(1);
            end else begin
                if (s.tot != '1) nxt.tot = s.tot + CW'(1);
                if (cmd && s.hi != '1) nxt.hi = s.hi + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s <= '0;
        else s <= nxt;
    end

    assign cmd_lvl = s.lvl;
    assign high_run = s.hi;
    assign period = s.period;
    assign high = s.high;
    assign valid = s.valid;

    a_period_frozen: assert property (
        @(posedge pclk) disable iff (!presetn)
        hold && !clear |=> $stable(s.period))
        else $error("period changed during full duty");
endmodule

// >>> src/fmsi_hall_tach.sv
// Purpose: Hall comparator with hysteresis and divided tach output.
// Assumes: Hall inputs are digitised unsigned samples.
// Notes:   Tach toggles every div_n Hall edges.
module fmsi_hall_tach #(
    parameter int HW = 8,
    parameter int HYST = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [HW-1:0] hall_p,
    input wire logic [HW-1:0] hall_n,
    input wire logic [1:0] div_n,
    input wire logic enable,
    output logic hall_lvl,
    output logic hall_rise,
    output logic tach
);
    import fmsi_pkg::*;
    localparam logic signed [HW:0] HYS = (HW+1)'(HYST);
    typedef struct packed {
        logic lvl;
        logic rise;
        logic [1:0] cnt;
        logic tach;
    } fmsi_tach_t;
    fmsi_tach_t s, nxt;
    logic signed [HW:0] diff;

    assign diff = $signed({1'b0, hall_p}) - $signed({1'b0, hall_n});

    always_comb begin
        nxt = s;
        if (diff > HYS) nxt.lvl = 1'b1;
        else if (diff < -HYS) nxt.lvl = 1'b0;
        nxt.rise = nxt.lvl && !s.lvl;
        if (!enable) begin
            nxt.cnt = 2'h0;
            nxt.tach = 1'b0;
        end else if (nxt.lvl != s.lvl) begin
            if (s.cnt + 2'h1 >= div_n) begin
                nxt.cnt = 2'h0;
                nxt.tach = !s.tach;
            end else begin
                nxt.cnt = s.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s <= '0;
        else s <= nxt;
    end

    assign hall_lvl = s.lvl;
    assign hall_rise = s.rise;
    assign tach = s.tach;

    a_hall_hyst: assert property (
        @(posedge pclk) disable iff (!presetn)
        diff > HYS |=> s.lvl)
        else $error("hall level missed a positive crossing");
    a_tach_on_edge: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable ##1 $changed(s.tach) |-> $changed(s.lvl))
        else $error("tach toggled without a hall edge");
endmodule

// >>> src/fmsi_top.sv
// Purpose: Speed command front end, tach and start-up sequencer.
// Assumes: All pin inputs synchronous to pclk; APB slave registers.
// Notes:   Motor stays stopped while lockout or sleep is asserted.
//
// Our own choices: the APB register port and the placing of the registers.
`include "fmsi_consts.svh"

module fmsi_top #(
    parameter int CW = 16,
    parameter int LW = 8,
    parameter int HW = 8,
    parameter int HYST = 4,
    parameter int INIT_CYC = `FMSI_INIT_CYC,
    parameter logic [1:0] DIV1_CODE = 2'h0,
    parameter logic [1:0] DIV2_CODE = 2'h1,
    parameter logic [1:0] DIV3_CODE = 2'h2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic speed_command_input,
    input wire logic [HW-1:0] hall_positive_in,
    input wire logic [HW-1:0] hall_negative_in,
    input wire logic undervoltage_lockout,
    input wire logic sleep_in,
    input wire logic conduction_zero_in,
    output logic pwm_out,
    output logic drive_enable_out,
    output logic tach_pulse_out,
    output logic [CW-1:0] phase_shift_out
);
    import fmsi_pkg::*;

    // ****************************************************************
    // Types and state
    // ****************************************************************
    localparam int IW = $clog2(INIT_CYC + 1);
    localparam logic [CW-1:0] DEF_PERIOD = CW'(`FMSI_DEF_PERIOD);
    localparam logic [2:0] TICK_LAST = 3'(`FMSI_SAMPLE_CYC - 1);
    localparam logic [2:0] HALL_LAST = 3'(`FMSI_STARTUP_HALLS - 1);
    localparam logic [LW-1:0] TRI_TOP = '1;

    typedef struct packed {
        fmsi_state_t state;
        logic [IW-1:0] init_cnt;
        logic [2:0] tick_cnt;
        logic tick;
        logic [2:0] hall_cnt;
        logic full;
        logic mode_dc;
        logic ps_sel;
        logic [1:0] fgs;
        logic [LW-1:0] level;
        logic [LW-1:0] floor_lvl;
        logic [CW-1:0] pwm_cnt;
        logic [LW-1:0] tri_cnt;
        logic tri_dn;
        logic pwm;
        logic drv;
        logic [CW-1:0] shift;
        logic [CW-1:0] ph_cnt;
        logic ph_run;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fmsi_top_t;

    localparam fmsi_top_t RST_VAL = '{
        state: FMSI_ST_INIT,
        mode_dc: 1'(`FMSI_CTRL_RST >> `FMSI_CTRL_DC_BIT),
        level: LW'(`FMSI_LEVEL_RST),
        floor_lvl: LW'(`FMSI_FLOOR_RST),
        default: '0
    };

    fmsi_top_t s, nxt;

    logic m_lvl;
    logic [CW-1:0] m_run;
    logic [CW-1:0] m_period;
    logic [CW-1:0] m_high;
    logic m_valid;
    logic hall_lvl;
    logic hall_rise;
    logic tach_q;
    logic hold_req;
    logic [CW-1:0] ref_period;
    logic [CW+2:0] full_thr;
    logic [LW-1:0] eff_level;
    logic [1:0] div_n;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2:0] fmsi_decode(input logic [11:0] a);
        logic [2:0] ix;
        ix = `FMSI_IX_NONE;
        if (a == `FMSI_REG_CTRL) ix = `FMSI_IX_CTRL;
        else if (a == `FMSI_REG_LEVEL) ix = `FMSI_IX_LEVEL;
        else if (a == `FMSI_REG_FLOOR) ix = `FMSI_IX_FLOOR;
        else if (a == `FMSI_REG_STATUS) ix = `FMSI_IX_STATUS;
        else if (a == `FMSI_REG_PERIOD) ix = `FMSI_IX_PERIOD;
        else if (a == `FMSI_REG_HIGH) ix = `FMSI_IX_HIGH;
        else if (a == `FMSI_REG_SHIFT) ix = `FMSI_IX_SHIFT;
        return ix;
    endfunction

    function automatic logic [1:0] fmsi_div(input logic [1:0] code);
        logic [1:0] n;
        n = 2'h1;
        if (code == DIV2_CODE) n = 2'h2;
        else if (code == DIV3_CODE) n = 2'h3;
        else if (code == DIV1_CODE) n = 2'h1;
        return n;
    endfunction

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    fmsi_cmd_meter #(.CW(CW)) u_meter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(s.tick),
        .clear(s.state == FMSI_ST_INIT),
        .hold(s.full),
        .cmd(speed_command_input),
        .cmd_lvl(m_lvl),
        .high_run(m_run),
        .period(m_period),
        .high(m_high),
        .valid(m_valid)
    );

    fmsi_hall_tach #(.HW(HW), .HYST(HYST)) u_tach (
        .pclk(pclk),
        .presetn(presetn),
        .hall_p(hall_positive_in),
        .hall_n(hall_negative_in),
        .div_n(div_n),
        .enable(s.state == FMSI_ST_RUN),
        .hall_lvl(hall_lvl),
        .hall_rise(hall_rise),
        .tach(tach_q)
    );

    assign div_n = fmsi_div(s.fgs);
    assign hold_req = undervoltage_lockout | sleep_in;
    // Default carrier until a real period has been seen
    assign ref_period = m_valid ? m_period : DEF_PERIOD;
    assign full_thr = (CW+3)'(ref_period) * (CW+3)'(`FMSI_FULL_MULT);
    // A zero floor can never exceed the level, so it needs no special case
    assign eff_level = (s.floor_lvl > s.level) ? s.floor_lvl : s.level;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [2:0] ix;
        logic raw;
        ix = fmsi_decode(paddr);
        raw = 1'b0;
        nxt = s;

        // Sampling strobe, one pclk in five
        nxt.tick = (s.tick_cnt == TICK_LAST);
        nxt.tick_cnt = nxt.tick ? 3'h0 : s.tick_cnt + 3'h1;

        // Start-up sequencer
        case (s.state)
            FMSI_ST_INIT: begin
                nxt.hall_cnt = 3'h0;
                if (s.init_cnt == IW'(INIT_CYC - 1)) begin
                    nxt.state = FMSI_ST_START;
                    nxt.init_cnt = '0;
                end else begin
                    nxt.init_cnt = s.init_cnt + IW'(1);
                end
            end
            FMSI_ST_START: begin
                if (hall_rise) begin
                    nxt.hall_cnt = s.hall_cnt + 3'h1;
                    if (s.hall_cnt == HALL_LAST) nxt.state = FMSI_ST_RUN;
                end
            end
            FMSI_ST_RUN: begin
                nxt.hall_cnt = s.hall_cnt;
            end
            default: begin
                nxt.state = FMSI_ST_INIT;
            end
        endcase
        if (hold_req) begin
            nxt.state = FMSI_ST_INIT;
            nxt.init_cnt = '0;
        end

        // Full duty: high for seven carrier periods without a fall
        if (s.state == FMSI_ST_INIT) begin
            nxt.full = 1'b0;
        end else if (s.tick) begin
            nxt.full = !s.mode_dc && m_lvl &&
                ((CW+3)'(m_run) >= full_thr);
        end

        // Carrier counter and triangle ramp, stepped at sample rate
        if (s.tick) begin
            if (s.pwm_cnt >= ref_period - CW'(1)) begin
                nxt.pwm_cnt = '0;
            end else begin
                nxt.pwm_cnt = s.pwm_cnt + CW'(1);
            end
            if (s.tri_dn) begin
                nxt.tri_cnt = s.tri_cnt - LW'(1);
                if (s.tri_cnt == LW'(1)) nxt.tri_dn = 1'b0;
            end else begin
                nxt.tri_cnt = s.tri_cnt + LW'(1);
                if (s.tri_cnt == TRI_TOP - LW'(1)) nxt.tri_dn = 1'b1;
            end
        end

        if (s.mode_dc) begin
            raw = eff_level > s.tri_cnt;
        end else begin
            raw = s.full || (s.pwm_cnt < m_high);
        end
        nxt.drv = (s.state != FMSI_ST_INIT) && !hold_req;
        nxt.pwm = nxt.drv && raw;

        // Drive phase: ticks from Hall rise to conduction zero
        if (hall_rise) begin
            nxt.ph_cnt = '0;
            nxt.ph_run = 1'b1;
        end else if (s.ph_run && s.tick && s.ph_cnt != '1) begin
            nxt.ph_cnt = s.ph_cnt + CW'(1);
        end
        if (s.ps_sel) begin
            nxt.shift = '0;
        end else if (conduction_zero_in && s.ph_run) begin
            nxt.ph_run = 1'b0;
            // One step per Hall cycle keeps the correction smooth
            if (s.ph_cnt > s.shift) nxt.shift = s.shift + CW'(1);
            else if (s.ph_cnt < s.shift) nxt.shift = s.shift - CW'(1);
        end

        // APB: answer in the first access cycle
        nxt.pready = psel && !penable && !s.pready;
        nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            nxt.pslverr = (ix == `FMSI_IX_NONE);
            case (ix)
                `FMSI_IX_CTRL: nxt.prdata = 32'({s.fgs, s.ps_sel,
                    s.mode_dc});
                `FMSI_IX_LEVEL: nxt.prdata = 32'(s.level);
                `FMSI_IX_FLOOR: nxt.prdata = 32'(s.floor_lvl);
                `FMSI_IX_STATUS: nxt.prdata = 32'({hall_lvl, s.state,
                    m_valid, s.full});
                `FMSI_IX_PERIOD: nxt.prdata = 32'(ref_period);
                `FMSI_IX_HIGH: nxt.prdata = 32'(m_high);
                `FMSI_IX_SHIFT: nxt.prdata = 32'(s.shift);
                default: nxt.prdata = 32'h0;
            endcase
        end
        if (psel && penable && s.pready && pwrite) begin
            if (ix == `FMSI_IX_CTRL) begin
                nxt.mode_dc = pwdata[`FMSI_CTRL_DC_BIT];
                nxt.ps_sel = pwdata[`FMSI_CTRL_PS_BIT];
                nxt.fgs = pwdata[`FMSI_CTRL_FGS_LSB +: 2];
            end else if (ix == `FMSI_IX_LEVEL) begin
                nxt.level = pwdata[LW-1:0];
            end else if (ix == `FMSI_IX_FLOOR) begin
                nxt.floor_lvl = pwdata[LW-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s <= RST_VAL;
        else s <= nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pwm_out = s.pwm;
    assign drive_enable_out = s.drv;
    assign tach_pulse_out = tach_q;
    assign phase_shift_out = s.shift;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_tick_gap;
        !s.tick [*4] ##1 s.tick;
    endsequence

    sequence s_init_done;
        (s.state == FMSI_ST_INIT) ##1 (s.state == FMSI_ST_START);
    endsequence

    a_tick_spacing: assert property (
        s.tick |=> s_tick_gap)
        else $error("sample strobe not every fifth cycle");
    a_full_drive: assert property (
        s.full && !s.mode_dc && nxt.drv |=> pwm_out)
        else $error("full duty did not drive output high");
    a_default_carrier: assert property (
        !m_valid && s.tick && s.pwm_cnt == DEF_PERIOD - CW'(1) |=>
        s.pwm_cnt == '0) else $error("default carrier not used");
    a_track_period: assert property (
        m_valid && s.tick && s.pwm_cnt == m_period - CW'(1) |=>
        s.pwm_cnt == '0) else $error("carrier not tracking measured period");
    a_dc_compare: assert property (
        s.mode_dc && s.state == FMSI_ST_RUN && !hold_req &&
        eff_level > s.tri_cnt |=> pwm_out)
        else $error("dc compare did not raise output");
    a_floor_clamp: assert property (
        s.mode_dc && s.floor_lvl > s.level && s.tri_cnt >= s.floor_lvl
        |=> !pwm_out)
        else $error("floor clamp not applied");
    a_auto_phase: assert property (
        !s.ps_sel && conduction_zero_in && s.ph_run && !hall_rise &&
        s.ph_cnt > s.shift |=> phase_shift_out == $past(s.shift) + CW'(1))
        else $error("auto phase did not step up");
    a_fixed_phase: assert property (
        s.ps_sel |=> phase_shift_out == '0)
        else $error("fixed phase shift not zero");
    a_init_quiet: assert property (
        s.state == FMSI_ST_INIT |=> !pwm_out && !drive_enable_out)
        else $error("output active during init");
    a_init_length: assert property (
        s_init_done |-> $past(s.init_cnt, 1) == IW'(INIT_CYC - 1))
        else $error("init left before its full length");
    a_startup_tach: assert property (
        s.state != FMSI_ST_RUN ##1 s.state != FMSI_ST_RUN
        |-> !tach_pulse_out)
        else $error("tach active outside run");
endmodule

// >>> testbench/fmsi_host.sv
// Purpose: Host model driving the PWM speed command.
// Assumes: Period and high time in pclk cycles, multiples of 5.
// Notes:   mode 0 holds low, 1 runs PWM, 2 holds high.
module fmsi_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] mode,
    input wire logic [15:0] per,
    input wire logic [15:0] hi,
    output logic cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_ff;
    // ****************************************************************
    // Waveform
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0;
        end else begin
            cnt_ff <= (cnt_ff + 16'h1 >= per) ? 16'h0 : cnt_ff + 16'h1;
        end
    end
    // Stop is a steady low, never a floating pin
    // Callers keep per - hi above 63 cycles so lows exceed 500 ns
    assign cmd = (mode == 2'h2) || (mode == 2'h1 && cnt_ff < hi);
endmodule

// >>> testbench/fmsi_top_tb.sv
// Purpose: Self-checking bench for the speed input and start-up block.
// Assumes: INIT_CYC cut to 20 so start-up fits a short run.
// Notes:   Hall minus input held mid-scale; plus input swings.
`include "fmsi_consts.svh"
module fmsi_top_tb;
    import fmsi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ul = 1'b1, slp = 1'b0, cz = 1'b0, tach_q = 1'b0;
    logic pready, pslverr, rerr, cmd, pwm, den, tach;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic [7:0] hp = 8'h40;
    logic [15:0] shift, per = 16'd250, hi = 16'd125;
    logic [1:0] mode = 2'h0;
    int errors = 0, n_tests = 0, cyc = 0, tog = 0;
    initial begin
        forever #4 pclk = ~pclk;
    end
    fmsi_top #(.INIT_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .speed_command_input(cmd),
        .hall_positive_in(hp), .hall_negative_in(8'h80),
        .undervoltage_lockout(ul), .sleep_in(slp),
        .conduction_zero_in(cz), .pwm_out(pwm), .drive_enable_out(den),
        .tach_pulse_out(tach), .phase_shift_out(shift));
    fmsi_host u_host (.pclk(pclk), .presetn(presetn), .mode(mode),
        .per(per), .hi(hi), .cmd(cmd));
    // Tach edge counter and hang guard
    always @(posedge pclk) begin
        cyc++;
        tach_q <= tach;
        if (tach !== tach_q) tog++;
        if (cyc == 40000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Marker trails each Hall rise by 2 or 3 sample ticks, never fewer
    task automatic hedge(input logic up);
        @(posedge pclk);
        hp <= up ? 8'hc0 : 8'h40;
        repeat (13) @(posedge pclk);
        cz <= up;
        @(posedge pclk);
        cz <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic dc_try(input logic [7:0] lv, input logic [7:0] fl,
                          input int lo, input int hi_);
        int n;
        n = 0;
        apb(1'b1, `FMSI_REG_LEVEL, {24'h0, lv});
        apb(1'b1, `FMSI_REG_FLOOR, {24'h0, fl});
        // One full ramp is 510 ticks of 5 pclk
        repeat (2550) begin
            @(posedge pclk);
            n += (pwm === 1'b1);
        end
        chk(32'(n >= lo && n <= hi_), 32'h1);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `FMSI_REG_CTRL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, `FMSI_REG_FLOOR, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, `FMSI_REG_PERIOD, 32'h0);
        apb(1'b0, `FMSI_REG_PERIOD, 32'h0);
        chk(rdat, `FMSI_DEF_PERIOD);
        apb(1'b0, 12'h01c, 32'h0);
        chk(32'(rerr), 32'h1);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[4:2]), 32'(FMSI_ST_INIT));
        chk(32'(den), 32'h0);
        ul <= 1'b0;
        repeat (25) @(posedge pclk);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[4:2]), 32'(FMSI_ST_START));
        chk(32'(den), 32'h1);
        $display("test lockout done");
        tog = 0;
        repeat (3) begin
            hedge(1'b1);
            hedge(1'b0);
        end
        hedge(1'b1);
        chk(tog, 0);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[4:2]), 32'(FMSI_ST_RUN));
        chk(32'(rdat[5]), 32'h1);
        hp <= 8'h7e;
        repeat (3) @(posedge pclk);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[5]), 32'h1);
        hedge(1'b0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `FMSI_REG_CTRL, 32'(c) << 2);
            tog = 0;
            repeat (6) begin
                hedge(1'b1);
                hedge(1'b0);
            end
            chk(tog, c == 1 ? 6 : (c == 2 ? 4 : 12));
        end
        apb(1'b0, `FMSI_REG_SHIFT, 32'h0);
        chk(32'(rdat >= 32'h2 && rdat <= 32'h3), 32'h1);
        apb(1'b1, `FMSI_REG_CTRL, 32'h2);
        hedge(1'b1);
        hedge(1'b0);
        apb(1'b0, `FMSI_REG_SHIFT, 32'h0);
        chk(rdat, 32'h0);
        chk(32'(shift), 32'h0);
        $display("test hall done");
        apb(1'b1, `FMSI_REG_CTRL, 32'h1);
        dc_try(8'h80, 8'h00, 1100, 1450);
        dc_try(8'h00, 8'h00, 0, 0);
        dc_try(8'h00, 8'h80, 1100, 1450);
        apb(1'b1, `FMSI_REG_CTRL, 32'h0);
        $display("test dc done");
        mode <= 2'h1;
        repeat (1500) @(posedge pclk);
        apb(1'b0, `FMSI_REG_PERIOD, 32'h0);
        chk(rdat, 32'd50);
        apb(1'b0, `FMSI_REG_HIGH, 32'h0);
        chk(rdat, 32'd25);
        while (cmd !== 1'b1) @(posedge pclk);
        mode <= 2'h2;
        repeat (1600) @(posedge pclk);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[0]), 32'h0);
        repeat (300) @(posedge pclk);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[0]), 32'h1);
        apb(1'b0, `FMSI_REG_PERIOD, 32'h0);
        chk(rdat, 32'd50);
        chk(32'(pwm), 32'h1);
        $display("test pwm done");
        slp <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'(den), 32'h0);
        slp <= 1'b0;
        repeat (30) @(posedge pclk);
        apb(1'b0, `FMSI_REG_PERIOD, 32'h0);
        chk(rdat, `FMSI_DEF_PERIOD);
        per <= 16'd200;
        hi <= 16'd100;
        mode <= 2'h1;
        repeat (1200) @(posedge pclk);
        apb(1'b0, `FMSI_REG_PERIOD, 32'h0);
        chk(rdat, 32'd40);
        apb(1'b0, `FMSI_REG_STATUS, 32'h0);
        chk(32'(rdat[1]), 32'h1);
        $display("test sleep done");
        wrap_up();
    end
endmodule
